/* File: core/reload_mem.sv */
// Table of counter reload values, one word per counter.
// Assumes writes and reads on the same core clock; read data registered.
module reload_mem (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic WE,
	input wire logic [2:0] WADDR,
	input wire logic [31:0] WDATA,
	input wire logic [2:0] RADDR,
	output logic [31:0] RDATA
);
	import sample_pkg::*;

	typedef struct packed {
		logic [NCNT-1:0][31:0] mem;
		logic [31:0] rdata;
	} mem_state_t;

	mem_state_t st_q;
	mem_state_t st_d;

	// Write port and registered read
	always_comb begin
		st_d = st_q;
		if (WE) begin
			st_d.mem[WADDR] = WDATA;
		end
		st_d.rdata = st_q.mem[RADDR];
	end

	// State register
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign RDATA = st_q.rdata;

endmodule : reload_mem

/* File: core/sample_builder.sv */
// Event sample record builder: packs basic and optional groups into
// a stream of 64-bit words. Assumes the core answers STATE_DATA in the
// same cycle for the group and index shown, and holds its committed
// state while CORE_HOLD is high.
//
// Our own choices: the APB register port and the placing of the registers.

module sample_builder (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire sample_pkg::apb_req_t APB_REQ,
	output sample_pkg::apb_rsp_t APB_RSP,
	input wire logic [sample_pkg::NGP-1:0] OVF_GP,
	input wire logic [sample_pkg::NFIX-1:0] OVF_FIX,
	input wire logic [sample_pkg::NGP-1:0] MEM_EVENT_GP,
	input wire logic [63:0] TRIG_IP,
	input wire logic [63:0] TIMESTAMP,
	input wire sample_pkg::mem_info_t MEM_INFO,
	input wire logic MODE64,
	input wire logic VEC_ENABLE,
	output logic CORE_HOLD,
	output sample_pkg::grp_t STATE_GROUP,
	output logic [9:0] STATE_INDEX,
	input wire logic [63:0] STATE_DATA,
	output sample_pkg::rec_out_t REC_OUT,
	input wire logic REC_READY,
	output sample_pkg::reload_t RELOAD
);
	import sample_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Words in one group for the given branch depth
	function automatic logic [9:0] group_words(grp_t g, logic [9:0] brn);
		logic [9:0] n;
		n = 10'h000;
		case (g)
			GRP_BASIC: n = BASIC_WORDS;
			GRP_MEM: n = MEM_WORDS;
			GRP_GREG: n = GREG_WORDS;
			GRP_VEC: n = VEC_WORDS;
			GRP_BR: n = brn * BR_WORDS_PER;
			GRP_CNT: n = CNT_WORDS;
			default: n = 10'h000;
		endcase
		return n;
	endfunction : group_words

	// Next included group after the current one, in fixed order
	function automatic grp_t next_group(grp_t g, logic [5:0] incl);
		grp_t r;
		r = GRP_NONE;
		for (int i = 5; i >= 0; i--) begin
			if (incl[i] && (6'(6'h01 << i) > g)) begin
				r = grp_t'(6'(6'h01 << i));
			end
		end
		return r;
	endfunction : next_group

	// Address decode of one register word
	function automatic logic is_reload(logic [11:0] a);
		return (a >= OFS_RELOAD_BASE) &&
			(a < OFS_RELOAD_BASE + 12'(4 * NCNT)) && (a[1:0] == 2'b00);
	endfunction : is_reload

	function automatic logic is_mapped(logic [11:0] a);
		return (a == OFS_CFG_LO) || (a == OFS_CFG_HI) ||
			(a == OFS_SAMPLE_EN) || (a == OFS_ADAPT) ||
			(a == OFS_STATUS) || is_reload(a);
	endfunction : is_mapped

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		fsm_t state;
		grp_t grp;
		logic [9:0] idx;
		logic [5:0] incl;
		logic [9:0] brn;
		logic [47:0] fmt;
		logic [15:0] size;
		logic [63:0] ip;
		logic [63:0] timestamp_counter;
		logic [NCNT-1:0] trig;
		logic [63:0] maddr;
		logic [63:0] maux;
		logic [63:0] mlat;
		logic [63:0] mtx;
		logic [NGP-1:0] pend_gp;
		logic [NFIX-1:0] pend_fix;
		logic [47:0] cfg;
		logic [NGP-1:0] gp_en;
		logic [NFIX-1:0] fix_en;
		logic [NGP-1:0] gp_adapt;
		logic [NFIX-1:0] fix_adapt;
		logic [31:0] prdata;
		logic [15:0] count;
		logic [3:0] ridx;
		logic rl_vld;
		logic [2:0] rl_idx;
		rec_out_t out;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic [31:0] rl_value;
	logic mem_we;
	logic [2:0] mem_waddr;
	logic [63:0] mask64;

	// Counter table of reload values
	reload_mem u_reload (
		.CORE_CLK(CORE_CLK),
		.NRST(NRST),
		.WE(mem_we),
		.WADDR(mem_waddr),
		.WDATA(APB_REQ.pwdata),
		.RADDR(st_q.ridx[2:0]),
		.RDATA(rl_value)
	);

	// Triggering counters: general from bit 0, fixed from bit MASK_FIX_LSB
	always_comb begin
		mask64 = '0;
		mask64[NGP-1:0] = st_q.trig[NGP-1:0];
		mask64[MASK_FIX_LSB +: NFIX] = st_q.trig[NCNT-1:NGP];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic wr;
		logic [NGP-1:0] new_gp;
		logic [NFIX-1:0] new_fix;
		logic adaptive;
		logic [47:0] cfg_eff;
		logic [5:0] incl;
		logic [9:0] brn;
		logic [15:0] bytes;
		logic [63:0] word;
		logic load;
		grp_t ng;
		wr = 1'b0;
		new_gp = '0;
		new_fix = '0;
		adaptive = 1'b0;
		cfg_eff = '0;
		incl = '0;
		brn = '0;
		bytes = '0;
		word = '0;
		load = 1'b0;
		ng = GRP_NONE;
		st_d = st_q;
		mem_we = 1'b0;
		mem_waddr = 3'(APB_REQ.paddr[11:2] - OFS_RELOAD_BASE[11:2]);

		// Register writes and setup-phase read capture
		wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
		if (wr) begin
			case (APB_REQ.paddr)
				OFS_CFG_LO: st_d.cfg[31:0] = APB_REQ.pwdata;
				OFS_CFG_HI: st_d.cfg[47:32] = APB_REQ.pwdata[15:0];
				OFS_SAMPLE_EN: begin
					st_d.gp_en = APB_REQ.pwdata[NGP-1:0];
					st_d.fix_en = APB_REQ.pwdata[FIX_LSB +: NFIX];
				end
				OFS_ADAPT: begin
					st_d.gp_adapt = APB_REQ.pwdata[NGP-1:0];
					st_d.fix_adapt = APB_REQ.pwdata[FIX_LSB +: NFIX];
				end
				default: mem_we = is_reload(APB_REQ.paddr);
			endcase
		end
		if (APB_REQ.psel && !APB_REQ.penable) begin
			st_d.prdata = '0;
			case (APB_REQ.paddr)
				OFS_CFG_LO: st_d.prdata = st_q.cfg[31:0];
				OFS_CFG_HI: st_d.prdata[15:0] = st_q.cfg[47:32];
				OFS_SAMPLE_EN: begin
					st_d.prdata[NGP-1:0] = st_q.gp_en;
					st_d.prdata[FIX_LSB +: NFIX] = st_q.fix_en;
				end
				OFS_ADAPT: begin
					st_d.prdata[NGP-1:0] = st_q.gp_adapt;
					st_d.prdata[FIX_LSB +: NFIX] = st_q.fix_adapt;
				end
				OFS_STATUS: begin
					st_d.prdata[STAT_BUSY] = st_q.state != ST_IDLE;
					st_d.prdata[STAT_OUT_VALID] = st_q.out.valid;
					st_d.prdata[STAT_COUNT_LSB +: 16] = st_q.count;
				end
				default: st_d.prdata = '0;
			endcase
		end

		// Overflows of enabled counters wait until taken
		new_gp = OVF_GP & st_q.gp_en;
		new_fix = OVF_FIX & st_q.fix_en;
		adaptive = |(st_q.pend_gp & st_q.gp_adapt) |
			|(st_q.pend_fix & st_q.fix_adapt);
		cfg_eff = adaptive ? st_q.cfg : 48'h0000_0000_0000;
		incl = {cfg_eff[SEL_CNT], cfg_eff[SEL_BR], cfg_eff[SEL_VEC],
			cfg_eff[SEL_GREG], cfg_eff[SEL_MEM], 1'b1};
		brn = 10'(cfg_eff[BR_LSB +: BR_W]) + 10'h001;
		for (int i = 0; i < 6; i++) begin
			if (incl[i]) begin
				bytes = bytes + 16'(group_words(grp_t'(6'(6'h01 << i)),
					brn)) * 16'(WORD_BYTES);
			end
		end

		// Output word register accepts a new word when free
		if (REC_READY) begin
			st_d.out.valid = 1'b0;
		end
		load = !st_q.out.valid || REC_READY;

		// Word of the current group and index
		unique case (st_q.grp)
			GRP_BASIC: begin
				unique case (st_q.idx[1:0])
					2'h0: word = {st_q.size, st_q.fmt};
					2'h1: word = st_q.ip;
					2'h2: word = mask64;
					2'h3: word = st_q.timestamp_counter;
				endcase
			end
			GRP_MEM: begin
				unique case (st_q.idx[1:0])
					2'h0: word = st_q.maddr;
					2'h1: word = st_q.maux;
					2'h2: word = st_q.mlat;
					2'h3: word = st_q.mtx;
				endcase
			end
			GRP_GREG: begin
				word = STATE_DATA;
				if (!MODE64 && st_q.idx >= GREG_EXT_LO) begin
					word = '0;
				end else if (!MODE64 && st_q.idx >= GREG_LEGACY_LO) begin
					word[63:32] = '0;
				end
			end
			GRP_VEC: begin
				word = STATE_DATA;
				if (!VEC_ENABLE || (!MODE64 && st_q.idx >= VEC_HIGH_LO)) begin
					word = '0;
				end
			end
			GRP_BR, GRP_CNT: word = STATE_DATA;
			GRP_NONE: word = '0;
		endcase
		ng = next_group(st_q.grp, st_q.incl);

		// Reload pipeline: table read lags the index by one cycle
		st_d.rl_vld = 1'b0;
		st_d.rl_idx = st_q.ridx[2:0];

		unique case (st_q.state)
			ST_IDLE: begin
				if ((|st_q.pend_gp) || (|st_q.pend_fix)) begin
					st_d.state = ST_EMIT;
					st_d.grp = GRP_BASIC;
					st_d.idx = '0;
					st_d.incl = incl;
					st_d.brn = brn;
					st_d.fmt = cfg_eff;
					st_d.size = bytes;
					st_d.ip = TRIG_IP;
					st_d.timestamp_counter = TIMESTAMP;
					st_d.trig = {st_q.pend_fix, st_q.pend_gp};
					st_d.maddr = {{(63 - VA_MSB){MEM_INFO.addr[VA_MSB]}},
						MEM_INFO.addr[VA_MSB:0]};
					st_d.maux = '0;
					st_d.mlat = '0;
					if (|(st_q.pend_gp & MEM_EVENT_GP)) begin
						st_d.maux = MEM_INFO.is_store ?
							MEM_INFO.store_status :
							MEM_INFO.load_source;
						st_d.mlat = MEM_INFO.latency;
					end
					st_d.mtx = {MEM_INFO.tx_abort, MEM_INFO.tx_cycles};
					st_d.pend_gp = '0;
					st_d.pend_fix = '0;
				end
			end
			ST_EMIT: begin
				if (load) begin
					st_d.out.valid = 1'b1;
					st_d.out.data = word;
					st_d.out.last = 1'b0;
					if (st_q.idx == group_words(st_q.grp, st_q.brn) - 10'h001) begin
						st_d.idx = '0;
						st_d.grp = ng;
						if (ng == GRP_NONE) begin
							st_d.out.last = 1'b1;
							st_d.state = ST_RELOAD;
							st_d.ridx = '0;
							st_d.count = st_q.count + 16'h0001;
						end
					end else begin
						st_d.idx = st_q.idx + 10'h001;
					end
				end
			end
			ST_RELOAD: begin
				st_d.rl_vld = st_q.trig[st_q.ridx[2:0]];
				st_d.ridx = st_q.ridx + 4'h1;
				if (st_q.ridx == 4'(NCNT - 1)) begin
					st_d.state = ST_IDLE;
					st_d.grp = GRP_NONE;
				end
			end
		endcase

		// New overflows are never lost to the take
		st_d.pend_gp = st_d.pend_gp | new_gp;
		st_d.pend_fix = st_d.pend_fix | new_fix;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			st_q <= '0;
			st_q.state <= ST_IDLE;
			st_q.grp <= GRP_NONE;
			st_q.cfg <= CFG_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Bus answer: zero wait, error on unmapped address
	assign APB_RSP.pready = 1'b1;
	assign APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable &&
		!is_mapped(APB_REQ.paddr);
	assign APB_RSP.prdata = st_q.prdata;

	// Core holds committed state for the whole record
	assign CORE_HOLD = st_q.state != ST_IDLE;
	assign STATE_GROUP = st_q.grp;
	assign STATE_INDEX = st_q.idx;
	assign REC_OUT = st_q.out;

	// Reload strobe per triggering counter
	assign RELOAD.stb = st_q.rl_vld;
	assign RELOAD.sel = st_q.rl_idx;
	assign RELOAD.value = rl_value;

endmodule : sample_builder

/* File: core/sample_pkg.sv */
// Constants, types and carriers for the sample record builder.
// Assumes one core clock domain and an APB register port.
package sample_pkg;

	// ----------------------------------------
	// Counter set
	// ----------------------------------------
	localparam int NGP = 4;
	localparam int NFIX = 4;
	localparam int NCNT = NGP + NFIX;

	// ----------------------------------------
	// Register offsets and fields
	// ----------------------------------------
	localparam logic [11:0] OFS_CFG_LO = 12'h000;
	localparam logic [11:0] OFS_CFG_HI = 12'h004;
	localparam logic [11:0] OFS_SAMPLE_EN = 12'h008;
	localparam logic [11:0] OFS_ADAPT = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_RELOAD_BASE = 12'h040;
	localparam int FIX_LSB = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_OUT_VALID = 1;
	localparam int STAT_COUNT_LSB = 16;
	localparam logic [47:0] CFG_RESET = 48'h0000_0000_0000;

	// Group select bits and branch depth field
	localparam int SEL_MEM = 0;
	localparam int SEL_GREG = 1;
	localparam int SEL_VEC = 2;
	localparam int SEL_BR = 3;
	localparam int SEL_CNT = 4;
	localparam int BR_LSB = 24;
	localparam int BR_W = 8;

	// ----------------------------------------
	// Record layout
	// ----------------------------------------
	localparam int WORD_BYTES = 8;
	localparam int MASK_FIX_LSB = 32;
	localparam int VA_MSB = 47;
	localparam logic [9:0] BASIC_WORDS = 10'h004;
	localparam logic [9:0] MEM_WORDS = 10'h004;
	localparam logic [9:0] GREG_WORDS = 10'h012;
	localparam logic [9:0] GREG_LEGACY_LO = 10'h002;
	localparam logic [9:0] GREG_EXT_LO = 10'h00A;
	localparam logic [9:0] VEC_WORDS = 10'h020;
	localparam logic [9:0] VEC_HIGH_LO = 10'h010;
	localparam logic [9:0] BR_WORDS_PER = 10'h003;
	localparam logic [9:0] CNT_WORDS = 10'h008;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EMIT = 3'b010,
		ST_RELOAD = 3'b100
	} fsm_t;

	typedef enum logic [5:0] {
		GRP_NONE = 6'h00,
		GRP_BASIC = 6'h01,
		GRP_MEM = 6'h02,
		GRP_GREG = 6'h04,
		GRP_VEC = 6'h08,
		GRP_BR = 6'h10,
		GRP_CNT = 6'h20
	} grp_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic [63:0] addr;
		logic is_store;
		logic [63:0] load_source;
		logic [63:0] store_status;
		logic [63:0] latency;
		logic [31:0] tx_cycles;
		logic [31:0] tx_abort;
	} mem_info_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [63:0] data;
	} rec_out_t;

	typedef struct packed {
		logic stb;
		logic [2:0] sel;
		logic [31:0] value;
	} reload_t;

endpackage : sample_pkg

/* File: verification/core_model.sv */
// Core stand-in: committed state source and record sink.
// Assumes group and index from the builder; answers in the same cycle.
module core_model (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic STALL,
	input wire sample_pkg::grp_t STATE_GROUP,
	input wire logic [9:0] STATE_INDEX,
	output logic [63:0] STATE_DATA,
	output logic REC_READY
);
	timeunit 1ns;
	timeprecision 1ns;
	import sample_pkg::*;
	logic toggle_q;
	// Word names its group and index; state held while asked
	assign STATE_DATA = {16'hA5A5, 10'h000, STATE_GROUP, 22'h0, STATE_INDEX};
	// Sink takes every other cycle when stalling
	always_ff @(posedge CORE_CLK) begin
		toggle_q <= NRST ? ~toggle_q : 1'b0;
	end
	assign REC_READY = !STALL || toggle_q;
endmodule : core_model

/* File: verification/sample_builder_checker.sv */
// Port checker for the sample record builder.
// Assumes a bind onto sample_builder and one clock domain.
module sample_builder_checker (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire sample_pkg::apb_req_t APB_REQ,
	input wire sample_pkg::apb_rsp_t APB_RSP,
	input wire logic CORE_HOLD,
	input wire sample_pkg::grp_t STATE_GROUP,
	input wire logic [9:0] STATE_INDEX,
	input wire sample_pkg::rec_out_t REC_OUT,
	input wire logic REC_READY,
	input wire sample_pkg::reload_t RELOAD
);
	timeunit 1ns;
	timeprecision 1ns;
	import sample_pkg::*;
	// ------
	// Properties
	// ------
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	property p_ready;
		APB_REQ.psel |-> APB_RSP.pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_map;
		APB_REQ.psel && APB_REQ.penable && APB_REQ.paddr == OFS_CFG_HI
			|-> !APB_RSP.pslverr;
	endproperty
	a_map: assert property (p_map) else $error("select refused");
	property p_start;
		$rose(CORE_HOLD) |-> STATE_GROUP == GRP_BASIC ##1 REC_OUT.valid;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_size;
		$rose(REC_OUT.valid) |-> REC_OUT.data[63:48] >= 16'h0020
			&& REC_OUT.data[50:48] == 3'h0;
	endproperty
	a_size: assert property (p_size) else $error("bad size");
	property p_stall;
		REC_OUT.valid && !REC_READY |=> REC_OUT.valid
			&& $stable(REC_OUT.data) && $stable(REC_OUT.last);
	endproperty
	a_stall: assert property (p_stall) else $error("word lost");
	property p_end;
		REC_OUT.valid && REC_OUT.last && REC_READY |=> !REC_OUT.valid [*2];
	endproperty
	a_end: assert property (p_end) else $error("word after last");
	property p_reload;
		RELOAD.stb |-> CORE_HOLD || $past(CORE_HOLD);
	endproperty
	a_reload: assert property (p_reload) else $error("stray reload");
	property p_ascend;
		RELOAD.stb ##1 RELOAD.stb |-> RELOAD.sel > $past(RELOAD.sel);
	endproperty
	a_ascend: assert property (p_ascend) else $error("reload order");
	property p_idle;
		!CORE_HOLD |-> STATE_GROUP == GRP_NONE;
	endproperty
	a_idle: assert property (p_idle) else $error("group when idle");
endmodule : sample_builder_checker

/* File: verification/sample_builder_tb.sv */
// Self-checking bench for the sample record builder.
// Assumes the core stand-in and the checker compile first.
module sample_builder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sample_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	apb_req_t apb_req = '0;
	apb_rsp_t apb_rsp;
	logic [3:0] ovf_gp = 4'h0;
	logic [3:0] ovf_fix = 4'h0;
	logic [3:0] mem_ev = 4'hF;
	logic [63:0] ip = 64'h0000_7FFF_0040_1000;
	logic [63:0] ts = 64'h0000_0123_4567_89AB;
	mem_info_t mi = '{64'h0000_8000_1234_5678, 1'b0, 64'h3, 64'h5A,
		64'h96, 32'h77, 32'h1};
	logic mode64 = 1'b1;
	logic vec_en = 1'b1;
	logic stall = 1'b0;
	logic hold, rdy;
	grp_t grp;
	logic [9:0] idx;
	logic [63:0] sdata;
	rec_out_t rec;
	reload_t rl;
	int fails = 0;
	int compares = 0;
	int lastpos = -1;
	logic [63:0] recq[$];
	logic [63:0] expq[$];
	logic [34:0] rlq[$];
	always #50 core_clk = ~core_clk;
	sample_builder DUT (.CORE_CLK(core_clk), .NRST(nrst), .APB_REQ(apb_req),
		.APB_RSP(apb_rsp), .OVF_GP(ovf_gp), .OVF_FIX(ovf_fix),
		.MEM_EVENT_GP(mem_ev), .TRIG_IP(ip), .TIMESTAMP(ts), .MEM_INFO(mi),
		.MODE64(mode64), .VEC_ENABLE(vec_en), .CORE_HOLD(hold),
		.STATE_GROUP(grp), .STATE_INDEX(idx), .STATE_DATA(sdata),
		.REC_OUT(rec), .REC_READY(rdy), .RELOAD(rl));
	core_model core_i (.CORE_CLK(core_clk), .NRST(nrst), .STALL(stall),
		.STATE_GROUP(grp), .STATE_INDEX(idx), .STATE_DATA(sdata),
		.REC_READY(rdy));
	// ------
	// Monitor and helpers
	// ------
	always @(posedge core_clk) begin
		if (rec.valid && rdy) begin
			recq.push_back(rec.data);
			if (rec.last) lastpos = recq.size();
		end
		if (rl.stb) rlq.push_back({rl.sel, rl.value});
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task close_out;
		if (fails == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	function logic [31:0] rv(input logic [2:0] s);
		return {16'hBEEF, 13'h0, s};
	endfunction : rv
	// APB transfer: setup, then access until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [32:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (!apb_rsp.pready && n < 20);
		if (!apb_rsp.pready) begin
			fails++;
			close_out();
		end
		r = {apb_rsp.pslverr, apb_rsp.prdata};
		apb_req <= '0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task rd(input logic [11:0] a, input logic [32:0] exp);
		logic [32:0] r;
		apb(1'b0, a, 32'h0, r);
		chk({31'h0, r}, {31'h0, exp});
	endtask : rd
	// Pulse overflows and wait for the record and reloads
	task fire(input logic [3:0] g, input logic [3:0] f);
		int n;
		n = 0;
		recq.delete();
		rlq.delete();
		lastpos = -1;
		@(posedge core_clk);
		ovf_gp <= g;
		ovf_fix <= f;
		@(posedge core_clk);
		ovf_gp <= 4'h0;
		ovf_fix <= 4'h0;
		do @(posedge core_clk); while (!hold && ++n < 10);
		n = 0;
		while (hold && n < 900) begin
			@(posedge core_clk);
			n++;
		end
		// One more edge so the monitor takes the final reload strobe
		@(posedge core_clk);
		if (hold || n == 0) begin
			fails++;
			close_out();
		end
	endtask : fire
	task basic(input logic [47:0] fmt, input int w, input logic [63:0] m);
		expq.delete();
		expq.push_back({16'(w * 8), fmt});
		expq.push_back(ip);
		expq.push_back(m);
		expq.push_back(ts);
	endtask : basic
	task memw(input logic [63:0] aux, input logic [63:0] lat);
		expq.push_back({16'hFFFF, mi.addr[47:0]});
		expq.push_back(aux);
		expq.push_back(lat);
		expq.push_back({mi.tx_abort, mi.tx_cycles});
	endtask : memw
	task cmp_rec;
		chk(64'(recq.size()), 64'(expq.size()));
		chk(64'(lastpos), 64'(expq.size()));
		foreach (expq[i]) chk(i < recq.size() ? recq[i] : 'x, expq[i]);
	endtask : cmp_rec
	task cmp_rl(input int n, input logic [2:0] s0, input logic [2:0] s1);
		chk(64'(rlq.size()), 64'(n));
		if (rlq.size() > 0) chk(64'(rlq[0]), {29'h0, s0, rv(s0)});
		if (n > 1 && rlq.size() > 1) chk(64'(rlq[1]), {29'h0, s1, rv(s1)});
	endtask : cmp_rl
	// ------
	// Scenarios
	// ------
	task s_regs;
		rd(OFS_CFG_LO, 33'h0);
		rd(12'h0FC, 33'h1_0000_0000);
		for (int i = 0; i < 8; i++) wr(OFS_RELOAD_BASE + 12'(4 * i), rv(3'(i)));
		rd(OFS_RELOAD_BASE, 33'h0);
		wr(OFS_SAMPLE_EN, 32'h0003_0005);
		wr(OFS_ADAPT, 32'h0002_0004);
		wr(OFS_CFG_LO, 32'h1);
		rd(OFS_CFG_LO, 33'h1);
	endtask : s_regs
	task s_basic;
		fire(4'b1001, 4'h0);
		basic(48'h0, 4, 64'h1);
		cmp_rec();
		cmp_rl(1, 3'h0, 3'h0);
		rd(OFS_STATUS, 33'h0_0001_0000);
	endtask : s_basic
	task s_mem;
		fire(4'b0100, 4'b0010);
		basic(48'h1, 8, 64'h2_0000_0004);
		memw(mi.load_source, mi.latency);
		cmp_rec();
		cmp_rl(2, 3'h2, 3'h5);
	endtask : s_mem
	task s_cnt;
		wr(OFS_CFG_LO, 32'h0100_0019);
		wr(OFS_CFG_HI, 32'h1234);
		stall <= 1'b1;
		fire(4'h0, 4'b0011);
		basic(48'h1234_0100_0019, 22, 64'h3_0000_0000);
		memw(64'h0, 64'h0);
		for (int i = 0; i < 6; i++)
			expq.push_back({16'hA5A5, 10'h0, GRP_BR, 22'h0, 10'(i)});
		for (int i = 0; i < 8; i++)
			expq.push_back({16'hA5A5, 10'h0, GRP_CNT, 22'h0, 10'(i)});
		cmp_rec();
		cmp_rl(2, 3'h4, 3'h5);
		stall <= 1'b0;
	endtask : s_cnt
	task s_wide;
		wr(OFS_CFG_HI, 32'h0);
		wr(OFS_CFG_LO, 32'h7);
		mode64 <= 1'b0;
		vec_en <= 1'b0;
		mi.is_store <= 1'b1;
		fire(4'b0100, 4'h0);
		basic(48'h7, 58, 64'h4);
		memw(mi.store_status, mi.latency);
		for (int i = 0; i < 18; i++)
			expq.push_back(i < 10 ? {i < 2 ? 32'hA5A5_0000 | 32'(GRP_GREG)
				: 32'h0, 22'h0, 10'(i)} : 64'h0);
		for (int i = 0; i < 32; i++) expq.push_back(64'h0);
		cmp_rec();
	endtask : s_wide
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		s_regs();
		s_basic();
		s_mem();
		s_cnt();
		s_wide();
		close_out();
	end
endmodule : sample_builder_tb
bind sample_builder sample_builder_checker chk_i (.CORE_CLK(CORE_CLK),
	.NRST(NRST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .CORE_HOLD(CORE_HOLD),
	.STATE_GROUP(STATE_GROUP), .STATE_INDEX(STATE_INDEX), .REC_OUT(REC_OUT),
	.REC_READY(REC_READY), .RELOAD(RELOAD));
